// ==== verilog/mpe_port.sv ====
// Maintenance port: APB slave with parity checking and level 0 interrupt
//
// Local design decisions: the APB slave port and the register addresses.
module mpe_port
    import mpe_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic maint_par,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [7:0] io_addr,
    output logic io_addr_par,
    output logic [31:0] io_wdata,
    output logic io_we,
    output logic io_req,
    input wire logic io_ack,
    input wire logic [31:0] io_rdata,
    output logic lvl0_irq,
    output logic irq
);
    mpe_state_t state_reg;
    logic [7:0] tmo_cnt_reg;
    logic down_reg;
    logic test_reg;
    logic [MPE_NFLAG-1:0] flag_reg;
    logic [MPE_NFLAG-1:0] ist_reg;
    logic [MPE_NFLAG-1:0] ien_reg;
    logic [MPE_NFLAG-1:0] ev;
    logic [MPE_NFLAG-1:0] flag_clr;
    logic [MPE_NFLAG-1:0] ist_clr;
    logic setup;
    logic done_acc;
    logic wr_done;
    logic in_win;
    logic mpar_bad;
    logic known;
    logic [31:0] rd_local;

    // Bus phase decode
    assign setup = psel && !penable;
    assign done_acc = psel && penable && (state_reg == MPE_DONE);
    assign wr_done = done_acc && pwrite;
    assign in_win = (paddr & MPE_WIN_MASK) == MPE_WIN_BASE;
    assign known = in_win || paddr == MPE_ZERO_OFS || paddr == MPE_ST1_OFS
        || paddr == MPE_ST2_OFS || paddr == MPE_IST_OFS
        || paddr == MPE_ICLR_OFS || paddr == MPE_IEN_OFS;

    // Odd parity over address byte, plus low data byte on writes
    assign mpar_bad = ~^{paddr, (pwrite ? pwdata[7:0] : 8'h00), maint_par};

    // Error events raised by the sequencer
    always_comb begin
        ev = '0;
        ev[MPE_MP_BIT] = setup && mpar_bad;
        ev[MPE_DN_BIT] = setup && !pwrite && down_reg;
        ev[MPE_CP_BIT] = (state_reg == MPE_CHECK) && !(^{io_addr, io_addr_par});
        ev[MPE_TO_BIT] = (state_reg == MPE_WAIT) && !io_ack
            && tmo_cnt_reg == MPE_TMO_LIM;
    end

    // Write-one-to-clear masks
    assign flag_clr = (wr_done && paddr == MPE_ST2_OFS) ? pwdata[MPE_NFLAG-1:0] : '0;
    assign ist_clr = (wr_done && paddr == MPE_ICLR_OFS) ? pwdata[MPE_NFLAG-1:0] : '0;

    // Local register read mux
    always_comb begin
        rd_local = MPE_ZERO_WORD;
        case (paddr)
            MPE_ST1_OFS: rd_local[MPE_DOWN_BIT] = down_reg;
            MPE_ST2_OFS: begin
                rd_local[MPE_NFLAG-1:0] = flag_reg;
                rd_local[MPE_TEST_BIT] = test_reg;
            end
            MPE_IST_OFS: rd_local[MPE_NFLAG-1:0] = ist_reg;
            MPE_IEN_OFS: rd_local[MPE_NFLAG-1:0] = ien_reg;
            default: rd_local = MPE_ZERO_WORD;
        endcase
    end

    // Access sequencer: setup, parity check, optional central wait, done
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_reg <= MPE_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= MPE_ZERO_WORD;
            io_req <= 1'b0;
            tmo_cnt_reg <= 8'h00;
        end else begin
            case (state_reg)
                MPE_IDLE: begin
                    if (setup) begin
                        state_reg <= MPE_CHECK;
                    end
                end
                MPE_CHECK: begin
                    tmo_cnt_reg <= 8'h00;
                    if (in_win && !down_reg) begin
                        io_req <= 1'b1;
                        state_reg <= MPE_WAIT;
                    end else begin
                        prdata <= (in_win || pwrite) ? MPE_ZERO_WORD : rd_local;
                        pslverr <= !known;
                        pready <= 1'b1;
                        state_reg <= MPE_DONE;
                    end
                end
                MPE_WAIT: begin
                    if (io_ack) begin
                        io_req <= 1'b0;
                        prdata <= pwrite ? MPE_ZERO_WORD : io_rdata;
                        pready <= 1'b1;
                        state_reg <= MPE_DONE;
                    end else if (tmo_cnt_reg == MPE_TMO_LIM) begin
                        io_req <= 1'b0;
                        prdata <= MPE_ZERO_WORD;
                        pslverr <= 1'b1;
                        pready <= 1'b1;
                        state_reg <= MPE_DONE;
                    end else begin
                        tmo_cnt_reg <= tmo_cnt_reg + 8'h01;
                    end
                end
                MPE_DONE: begin
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                    state_reg <= MPE_IDLE;
                end
                default: state_reg <= MPE_IDLE;
            endcase
        end
    end

    // Address/data bus towards the central control unit
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            io_addr <= 8'h00;
            io_addr_par <= 1'b1;
            io_wdata <= MPE_ZERO_WORD;
            io_we <= 1'b0;
        end else if (setup) begin
            io_addr <= paddr;
            io_addr_par <= ~^paddr ^ test_reg;
            io_wdata <= pwdata;
            io_we <= pwrite;
        end
    end

    // Status one and test bit, written at completion
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            down_reg <= 1'b0;
            test_reg <= 1'b0;
        end else if (wr_done) begin
            if (paddr == MPE_ST1_OFS) begin
                down_reg <= pwdata[MPE_DOWN_BIT];
            end
            if (paddr == MPE_ST2_OFS) begin
                test_reg <= pwdata[MPE_TEST_BIT];
            end
        end
    end

    // Sticky status two flags; a new event beats a clear
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            flag_reg <= MPE_FLAG_RST;
        end else begin
            flag_reg <= (flag_reg & ~flag_clr) | ev;
        end
    end

    // Interrupt status, enable and outputs
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ist_reg <= MPE_FLAG_RST;
            ien_reg <= MPE_FLAG_RST;
            irq <= 1'b0;
            lvl0_irq <= 1'b0;
        end else begin
            ist_reg <= (ist_reg & ~ist_clr) | ev;
            if (wr_done && paddr == MPE_IEN_OFS) begin
                ien_reg <= pwdata[MPE_NFLAG-1:0];
            end
            irq <= |(ist_reg & ien_reg);
            lvl0_irq <= |flag_reg;
        end
    end

    // All checks run on the one clock and rest while reset is low
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    // A read in the down state flags the access and raises level 0
    down_read_a: assert property (
        setup && !pwrite && down_reg |=> flag_reg[MPE_DN_BIT] ##1 lvl0_irq)
        else $error("read while down did not raise level 0");

    // Test bit must corrupt the latched address parity
    test_par_a: assert property (
        setup && test_reg |=> !(^{io_addr, io_addr_par}))
        else $error("test bit did not force bad parity");

    // Test read reaches the central parity flag two edges after setup
    test_rd_a: assert property (
        setup && !pwrite && test_reg |-> ##2 flag_reg[MPE_CP_BIT])
        else $error("test read did not set central parity flag");

    // Test write likewise, with the level 0 line one edge later
    test_wr_a: assert property (
        setup && pwrite && test_reg |-> ##2 flag_reg[MPE_CP_BIT] ##1 lvl0_irq)
        else $error("test write did not raise level 0");

    // Address zero always answers with an empty word
    zero_rd_a: assert property (
        done_acc && !pwrite && paddr == MPE_ZERO_OFS |-> prdata == MPE_ZERO_WORD)
        else $error("address zero read not zero");

    // Bad parity from the maintenance side is flagged and raises level 0
    mpar_err_a: assert property (
        setup && mpar_bad |=> flag_reg[MPE_MP_BIT] ##1 lvl0_irq)
        else $error("bus parity error not flagged");

    // Central timeout flags the cause and ends the transfer
    tmo_flag_a: assert property (
        state_reg == MPE_WAIT && !io_ack && tmo_cnt_reg == MPE_TMO_LIM
        |=> flag_reg[MPE_TO_BIT] && pready)
        else $error("timeout not flagged");

    // The central parity flag only falls when software clears it
    flag_hold_a: assert property (
        flag_reg[MPE_CP_BIT] && !flag_clr[MPE_CP_BIT] |=> flag_reg[MPE_CP_BIT])
        else $error("error flag dropped without clear");

    // An enabled status bit drives the maskable interrupt
    irq_out_a: assert property (
        (ist_reg & ien_reg) != '0 |=> irq)
        else $error("enabled status did not raise irq");

    // Forwarded access always ends, answered or timed out
    wait_bound_a: assert property (
        state_reg == MPE_CHECK && in_win && !down_reg |-> ##[1:202] pready)
        else $error("central access not answered in time");

    // Ready is a single-cycle pulse
    ready_pulse_a: assert property (
        pready |=> !pready)
        else $error("ready held longer than one cycle");

    // Error response only comes together with ready
    err_ready_a: assert property (
        pslverr |-> pready)
        else $error("error response without ready");

    // Central request drops once the answer is taken
    req_drop_a: assert property (
        io_req && io_ack |=> !io_req)
        else $error("central request stayed up after answer");

    // Only window addresses are ever forwarded
    req_window_a: assert property (
        io_req |-> (io_addr & MPE_WIN_MASK) == MPE_WIN_BASE)
        else $error("request outside the forwarded window");

    // Down state keeps the central side quiet
    down_noreq_a: assert property (
        state_reg == MPE_CHECK && down_reg |=> !io_req)
        else $error("access forwarded while down");

    // Down state window reads return nothing
    down_zero_a: assert property (
        done_acc && !pwrite && down_reg && in_win |-> prdata == MPE_ZERO_WORD)
        else $error("window read while down returned data");

    // Level 0 follows any set flag
    lvl0_set_a: assert property (
        flag_reg != '0 |=> lvl0_irq)
        else $error("flag set but level 0 low");

    // Level 0 stays low with no cause
    lvl0_clr_a: assert property (
        flag_reg == '0 |=> !lvl0_irq)
        else $error("level 0 raised with no flag");

    // Without the test bit the address parity is good
    par_norm_a: assert property (
        setup && !test_reg |=> ^{io_addr, io_addr_par})
        else $error("address parity bad without test bit");

    // Every event lands in status two
    flag_set_a: assert property (
        ev != '0 |=> (flag_reg & $past(ev)) == $past(ev))
        else $error("event lost in status two");

    // Every event lands in interrupt status
    ist_set_a: assert property (
        ev != '0 |=> (ist_reg & $past(ev)) == $past(ev))
        else $error("event lost in interrupt status");

    // A clear with no new event empties the flags it names
    flag_clr_a: assert property (
        flag_clr != '0 && ev == '0 |=> (flag_reg & $past(flag_clr)) == '0)
        else $error("flag clear had no effect");

    // No enabled status keeps the interrupt low
    irq_low_a: assert property (
        (ist_reg & ien_reg) == '0 |=> !irq)
        else $error("irq raised with nothing enabled");

    // Wait counter never runs past its limit
    tmo_range_a: assert property (
        state_reg == MPE_WAIT |-> tmo_cnt_reg <= MPE_TMO_LIM)
        else $error("timeout counter overran");

    // Completion always returns the sequencer to idle
    done_idle_a: assert property (
        state_reg == MPE_DONE |=> state_reg == MPE_IDLE)
        else $error("sequencer stuck after completion");

    // Central read data is handed on with ready
    win_data_a: assert property (
        state_reg == MPE_WAIT && io_ack && !pwrite
        |=> pready && prdata == $past(io_rdata))
        else $error("central read data not returned");

    // Unmapped addresses answer with an error and no data
    unmapped_a: assert property (
        state_reg == MPE_CHECK && !known
        |=> pready && pslverr && prdata == MPE_ZERO_WORD)
        else $error("unmapped access not refused");

    // Main scenarios reached
    down_cov: cover property (setup && !pwrite && down_reg && paddr == MPE_ZERO_OFS);
    test_cov: cover property (setup && pwrite && test_reg);
    tmo_cov: cover property (ev[MPE_TO_BIT]);
    win_cov: cover property (state_reg == MPE_WAIT && io_ack);
    mpar_cov: cover property (ev[MPE_MP_BIT]);
endmodule

// ==== verilog/mpe_pkg.sv ====
// Constants for the maintenance port error-checking block
package mpe_pkg;
    // Register byte offsets on APB
    localparam logic [7:0] MPE_ZERO_OFS = 8'h00;
    localparam logic [7:0] MPE_ST1_OFS = 8'h04;
    localparam logic [7:0] MPE_ST2_OFS = 8'h08;
    localparam logic [7:0] MPE_IST_OFS = 8'h0C;
    localparam logic [7:0] MPE_ICLR_OFS = 8'h10;
    localparam logic [7:0] MPE_IEN_OFS = 8'h14;
    localparam logic [7:0] MPE_WIN_BASE = 8'h20;
    localparam logic [7:0] MPE_WIN_MASK = 8'hE0;
    // port_status_one fields
    localparam int MPE_DOWN_BIT = 0;
    // port_status_two fields (also the interrupt status layout)
    localparam int MPE_TO_BIT = 0;
    localparam int MPE_MP_BIT = 1;
    localparam int MPE_CP_BIT = 2;
    localparam int MPE_DN_BIT = 3;
    localparam int MPE_TEST_BIT = 4;
    localparam int MPE_NFLAG = 4;
    localparam logic [MPE_NFLAG-1:0] MPE_FLAG_RST = 4'h0;
    localparam logic [31:0] MPE_ZERO_WORD = 32'h0000_0000;
    // Central control unit answer timeout
    localparam int MPE_CLK_NS = 10;
    localparam int MPE_TMO_NS = 2000;
    localparam int MPE_TMO_CYC = MPE_TMO_NS / MPE_CLK_NS;
    localparam logic [7:0] MPE_TMO_LIM = 8'(MPE_TMO_CYC - 1);
    // Access sequencer states
    typedef enum logic [1:0] {
        MPE_IDLE = 2'b00,
        MPE_CHECK = 2'b01,
        MPE_WAIT = 2'b10,
        MPE_DONE = 2'b11
    } mpe_state_t;
endpackage

// ==== verif/mpe_ccu_model.sv ====
// Central control unit responder for the forwarded window
module mpe_ccu_model
    import mpe_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic io_req,
    input wire logic [7:0] lat,
    input wire logic [31:0] data,
    output logic io_ack,
    output logic [31:0] io_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt;
    logic done;
    // Ack lat+1 cycles after the request; lat of FF answers only after 256 cycles, past the 200-cycle port timeout; idle data toggles
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cnt <= 8'h00;
            done <= 1'b0;
            io_ack <= 1'b0;
            io_rdata <= 32'h0000_0000;
        end else begin
            io_ack <= 1'b0;
            io_rdata <= ~io_rdata;
            if (!io_req) begin
                cnt <= 8'h00;
                done <= 1'b0;
            end else if (!done) begin
                if (cnt == lat) begin
                    io_ack <= 1'b1;
                    io_rdata <= data;
                    done <= 1'b1;
                end
                cnt <= cnt + 8'h01;
            end
        end
    end
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench for the maintenance port
module tb_top import mpe_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, nrst, psel, penable, pwrite, maint_par, pready, pslverr, e, w;
    logic io_addr_par, io_we, io_req, io_ack, lvl0_irq, irq;
    logic [7:0] paddr, io_addr, lat, a;
    logic [31:0] pwdata, prdata, io_wdata, io_rdata, cdat, r, d;
    int bad_count = 0;
    int check_count = 0;
    mpe_port i_dut(.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .maint_par(maint_par),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .io_addr(io_addr),
        .io_addr_par(io_addr_par), .io_wdata(io_wdata), .io_we(io_we), .io_req(io_req),
        .io_ack(io_ack), .io_rdata(io_rdata), .lvl0_irq(lvl0_irq), .irq(irq));
    mpe_ccu_model i_ccu(.clock(clock), .nrst(nrst), .io_req(io_req), .lat(lat),
        .data(cdat), .io_ack(io_ack), .io_rdata(io_rdata));
    // Clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Expected address-bus parity: odd, inverted in test mode
    function automatic logic addr_par(input logic [7:0] x, input logic t);
        return ~^x ^ t;
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        if (bad_count == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // One APB transfer; bad inverts the maintenance parity bit
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
        input logic bad, output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        maint_par <= ~^{ad, wr ? wd[7:0] : 8'h00} ^ bad;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1 && n < 400) begin
            @(posedge clock);
            n++;
        end
        if (n >= 400) begin
            bad_count++;
            give_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic settle;
        repeat (2) @(posedge clock);
    endtask
    // Main sequence
    initial begin
        {nrst, psel, penable, pwrite, maint_par} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        lat = 8'h00;
        cdat = 32'h0;
        d = $urandom(16);
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        apb(0, MPE_ST2_OFS, 0, 0, r, e); chk(r, 32'h0);
        chk(io_addr_par, addr_par(MPE_ST2_OFS, 0));
        apb(0, MPE_ZERO_OFS, 0, 0, r, e); chk(r, 32'h0);
        settle; chk(lvl0_irq, 0);
        apb(1, MPE_IEN_OFS, 32'h2, 0, r, e);
        apb(1, MPE_ZERO_OFS, $urandom, 1, r, e);
        settle; chk({lvl0_irq, irq}, 2'b11);
        apb(0, MPE_IST_OFS, 0, 0, r, e); chk(r, 32'h2);
        apb(1, MPE_IEN_OFS, 0, 0, r, e);
        settle; chk({lvl0_irq, irq}, 2'b10);
        apb(1, MPE_ICLR_OFS, 32'h2, 0, r, e);
        settle; chk(lvl0_irq, 1);
        apb(0, MPE_IST_OFS, 0, 0, r, e); chk(r, 32'h0);
        apb(1, MPE_ST2_OFS, 32'h2, 0, r, e);
        settle; chk(lvl0_irq, 0);
        apb(0, 8'h18, 0, 0, r, e); chk({e, r}, 33'h1_0000_0000);
        apb(1, MPE_ST2_OFS, 32'h10, 0, r, e);
        settle; chk(lvl0_irq, 0);
        apb(0, MPE_ZERO_OFS, 0, 0, r, e); chk(io_addr_par, addr_par(8'h00, 1));
        settle; chk(lvl0_irq, 1);
        apb(1, MPE_ST2_OFS, 32'h0F, 0, r, e);
        apb(0, MPE_ST2_OFS, 0, 0, r, e); chk(r, 32'h0);
        apb(1, MPE_ST2_OFS, 32'h10, 0, r, e);
        apb(1, MPE_ZERO_OFS, $urandom, 0, r, e);
        settle; chk(lvl0_irq, 1);
        apb(0, MPE_ST2_OFS, 0, 0, r, e); chk(r, 32'h14);
        apb(1, MPE_ST2_OFS, 32'h0F, 0, r, e);
        // Software forces the down state, reads zero from the window and address zero
        apb(1, MPE_ST1_OFS, 32'h1, 0, r, e);
        lat <= 8'hFF;
        apb(0, MPE_WIN_BASE, 0, 0, r, e); chk({e, io_req, r}, 34'h0);
        apb(0, MPE_ZERO_OFS, 0, 0, r, e); chk(r, 32'h0);
        settle; chk(lvl0_irq, 1);
        apb(0, MPE_ST2_OFS, 0, 0, r, e); chk(r, 32'h8);
        apb(1, MPE_ST1_OFS, 0, 0, r, e);
        apb(1, MPE_ST2_OFS, 32'h0F, 0, r, e);
        apb(0, MPE_WIN_BASE, 0, 0, r, e); chk({e, r}, 33'h1_0000_0000);
        apb(0, MPE_ST2_OFS, 0, 0, r, e); chk(r, 32'h1);
        apb(1, MPE_ST2_OFS, 32'h0F, 0, r, e);
        // Random forwarded traffic with random answer delay
        repeat (12) begin
            lat <= 8'($urandom_range(0, 30));
            cdat <= $urandom;
            w = 1'($urandom);
            a = MPE_WIN_BASE | 8'($urandom_range(0, 31));
            d = $urandom;
            apb(w, a, d, 0, r, e); chk({e, io_addr}, {1'b0, a});
            chk(io_we, w);
            if (w) chk(io_wdata, d);
            else chk(r, cdat);
        end
        apb(0, MPE_ST2_OFS, 0, 0, r, e); chk(r, 32'h0);
        give_verdict();
    end
    // Hang limit
    initial begin
        #300000;
        bad_count++;
        give_verdict();
    end
endmodule
